// file: design/xcvr_seq_defines.svh
// Timing figures, register offsets and field positions for the reset sequencer.
// Assumes a 100 MHz parallel clock shared by both ends.
`ifndef XCVR_SEQ_DEFINES_SVH
`define XCVR_SEQ_DEFINES_SVH
// ==========================================================
// Timing
`define CLK_PERIOD_NS      10
`define PD_MIN_NS          1000
`define PD_CYCLES          ((`PD_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_NS          4000
`define SETTLE_CYCLES      ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ANALOG_WAIT_CYCLES 5
`define SIM_BUSY_CYCLES    20
`define PLLRST_CYCLES      4
`define LOCK_CYCLES        40
`define CDR_CYCLES         30
`define SCAN_DONE_CYCLES   8
`define SCAN_BITS          32
`define CNT_W              16
// ==========================================================
// Register map
`define REG_CFG            8'h00
`define REG_CMD            8'h04
`define REG_STATUS         8'h08
`define REG_SCAN           8'h0c
`define CFG_SIM_FAST       0
`define CFG_KIND_LSB       1
`define CFG_KIND_MSB       3
`define CMD_PLL            0
`define CMD_CHAN           1
`define CMD_PD             2
`endif

// file: design/xcvr_seq_pkg.sv
// Types shared by the sequencer ends.
// Assumes the defines header is compiled alongside.
`default_nettype none
package xcvr_seq_pkg;
  typedef enum logic [3:0] {
    S_IDLE, S_SHIFT, S_APPLY, S_WAIT_SCAN, S_PLL_RST, S_WAIT_LOCK, S_WAIT_ANALOG,
    S_WAIT_DLOCK, S_SETTLE, S_READY, S_WAIT_UPD, S_PD
  } seq_state_t;
  typedef logic [2:0] reconf_kind_t;
endpackage
`default_nettype wire

// file: design/xcvr_link_if.sv
// Link between user reset logic and the transceiver with its controllers.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface xcvr_link_if;
  logic                      tx_coding_reset;
  logic                      rx_analog_reset;
  logic                      rx_coding_reset;
  logic                      pll_reset;
  logic                      block_powerdown;
  logic                      scan_valid;
  logic                      scan_data;
  logic                      scan_apply;
  logic                      commit_all;
  xcvr_seq_pkg::reconf_kind_t kind_sel;
  logic                      elec_idle_force;
  logic                      pll_locked;
  logic                      data_lock;
  logic                      busy;
  logic                      scan_done;
  logic                      update_done;
  modport user_end (
    output tx_coding_reset, rx_analog_reset, rx_coding_reset, pll_reset, block_powerdown,
    output scan_valid, scan_data, scan_apply, commit_all, kind_sel, elec_idle_force,
    input  pll_locked, data_lock, busy, scan_done, update_done
  );
  modport device_end (
    input  tx_coding_reset, rx_analog_reset, rx_coding_reset, pll_reset, block_powerdown,
    input  scan_valid, scan_data, scan_apply, commit_all, kind_sel, elec_idle_force,
    output pll_locked, data_lock, busy, scan_done, update_done
  );
endinterface // xcvr_link_if
`default_nettype wire

// file: design/xcvr_device_end.sv
// Transceiver channel with its PLL and channel reconfiguration controllers.
// Assumes the user end obeys the reset ordering; same clock on both ends.
`timescale 1ns/1ps
`default_nettype none
`include "xcvr_seq_defines.svh"
module xcvr_device_end #(
  parameter int BUSY_CYCLES = `SIM_BUSY_CYCLES,
  parameter int SCAN_BITS   = `SCAN_BITS,
  parameter int LOCK_CYCLES = `LOCK_CYCLES,
  parameter int CDR_CYCLES  = `CDR_CYCLES
) (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  xcvr_link_if.device_end                 link,
  output logic                            link_up,
  output logic [SCAN_BITS-1:0]            rate_cfg,
  output xcvr_seq_pkg::reconf_kind_t      chan_kind
);
  logic [`CNT_W-1:0]     busy_cnt;
  logic                  chan_op;
  logic [`CNT_W-1:0]     scan_cnt;
  logic [SCAN_BITS-1:0]  scan_shadow;
  logic                  scan_wait;
  logic [`CNT_W-1:0]     scan_wait_cnt;
  logic [`CNT_W-1:0]     lock_cnt;
  logic [`CNT_W-1:0]     cdr_cnt;

  // ==========================================================
  // Busy: offset cancellation after reset, then only on commits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.busy        <= 1'b1;
      busy_cnt         <= '0;
      chan_op          <= 1'b0;
      link.update_done <= 1'b0;
      chan_kind        <= '0;
    end else begin
      link.update_done <= 1'b0;
      if (link.busy) begin
        busy_cnt <= busy_cnt + 1'b1;
        if (busy_cnt == `CNT_W'(BUSY_CYCLES - 1)) begin
          link.busy        <= 1'b0; // R15 R17
          link.update_done <= chan_op; // R9
          chan_op          <= 1'b0;
        end
      end else if (link.commit_all) begin
        link.busy <= 1'b1; // R8 R14
        busy_cnt  <= '0;
        chan_op   <= 1'b1;
        chan_kind <= link.kind_sel;
      end
    end
  end

  // ==========================================================
  // PLL scan chain
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scan_cnt       <= '0;
      scan_shadow    <= '0;
      scan_wait      <= 1'b0;
      scan_wait_cnt  <= '0;
      link.scan_done <= 1'b0;
      rate_cfg       <= '0;
    end else begin
      link.scan_done <= 1'b0;
      if (link.scan_valid) begin
        scan_shadow <= {link.scan_data, scan_shadow[SCAN_BITS-1:1]};
        scan_cnt    <= scan_cnt + 1'b1;
      end
      if (link.scan_apply && scan_cnt == `CNT_W'(SCAN_BITS)) begin
        scan_wait     <= 1'b1;
        scan_wait_cnt <= '0;
      end else if (scan_wait) begin
        scan_wait_cnt <= scan_wait_cnt + 1'b1;
        if (scan_wait_cnt == `CNT_W'(`SCAN_DONE_CYCLES - 1)) begin
          scan_wait      <= 1'b0;
          link.scan_done <= 1'b1; // R2
          rate_cfg       <= scan_shadow;
          scan_cnt       <= '0;
        end
      end
    end
  end

  // ==========================================================
  // PLL lock and CDR data lock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.pll_locked <= 1'b0;
      lock_cnt        <= '0;
    end else if (link.pll_reset || link.block_powerdown) begin
      link.pll_locked <= 1'b0;
      lock_cnt        <= '0;
    end else if (!link.pll_locked) begin
      lock_cnt <= lock_cnt + 1'b1;
      if (lock_cnt == `CNT_W'(LOCK_CYCLES - 1))
        link.pll_locked <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.data_lock <= 1'b0;
      cdr_cnt        <= '0;
    end else if (link.rx_analog_reset || !link.pll_locked || link.block_powerdown) begin
      link.data_lock <= 1'b0;
      cdr_cnt        <= '0;
    end else if (!link.data_lock) begin
      cdr_cnt <= cdr_cnt + 1'b1;
      if (cdr_cnt == `CNT_W'(CDR_CYCLES - 1))
        link.data_lock <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      link_up <= 1'b0;
    else
      link_up <= link.data_lock && !link.rx_coding_reset && !link.tx_coding_reset &&
                 !link.elec_idle_force;
  end
endmodule // xcvr_device_end
`default_nettype wire

// file: design/xcvr_user_end.sv
// User reset logic and PLL reconfiguration controller, with AHB-Lite registers.
// Assumes the device end on the same hclk; single word transfers only.
//
// Overview of operation
// (R1) Apply strobe only after last scan bit
// (R2) Device flags scan chain loading finished
// (R3) Pulse PLL reset after scan complete
// (R4) Hold resets until lock, then release tx
// (R5) Rx analog release five cycles after lock
// (R6) Settle after data lock, release rx coding
// (R7) Load kind, commit, assert all resets
// (R8) Controller raises busy at commit
// (R9) Controller flags channel update complete
// (R10) Tx release after done, before rx analog
// (R11) Rx analog release five cycles after done
// (R12) Data lock then settle, release rx coding
// (R13) Powerdown pulse at least one microsecond
// (R14) Busy only for cancellation or operations
// (R15) Busy falls when offset cancellation done
// (R16) No powerdown during offset cancellation
// (R17) Simulated busy falls after twenty cycles
// (R18) Simulation may skip settle wait
// (R19) Electrical idle forced before normal data
// (R20) Lock loss restarts from wait for lock
//
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "xcvr_seq_defines.svh"
module xcvr_user_end #(
  parameter int SCAN_BITS     = `SCAN_BITS,
  parameter int SETTLE_CYCLES = `SETTLE_CYCLES,
  parameter int PD_CYCLES     = `PD_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  xcvr_link_if.user_end    link
);
  xcvr_seq_pkg::seq_state_t state;
  logic [`CNT_W-1:0]        cnt;
  logic [SCAN_BITS-1:0]     shreg;
  logic [SCAN_BITS-1:0]     scan_word;
  logic                     sim_fast;
  xcvr_seq_pkg::reconf_kind_t kind;
  logic                     cmd_pll;
  logic                     cmd_chan;
  logic                     cmd_pd;
  logic [7:0]               lost_cnt;
  logic                     wr_pend;
  logic [7:0]               wr_addr;
  logic                     idle_ok;

  function automatic logic [31:0] read_word(input logic [7:0] a);
    unique case (a)
      `REG_CFG:    read_word = {28'h0000000, kind, sim_fast};
      `REG_STATUS: read_word = {16'h0000, lost_cnt, link.data_lock, link.pll_locked,
                                link.busy, state == xcvr_seq_pkg::S_READY, state};
      `REG_SCAN:   read_word = 32'(scan_word);
      default:     read_word = 32'h00000000;
    endcase
  endfunction

  // ==========================================================
  // AHB-Lite slave, zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
    end else begin
      wr_pend <= 1'b0;
      if (hready && hsel && htrans[1]) begin
        wr_pend <= hwrite;
        wr_addr <= haddr[7:0];
        if (!hwrite)
          hrdata <= read_word(haddr[7:0]);
      end
    end
  end

  // Commands are held until the sequencer is in idle or ready, then clear after one cycle even if busy blocks them
  assign idle_ok = (state == xcvr_seq_pkg::S_READY) || (state == xcvr_seq_pkg::S_IDLE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sim_fast  <= 1'b0;
      kind      <= '0;
      scan_word <= '0;
      cmd_pll   <= 1'b0;
      cmd_chan  <= 1'b0;
      cmd_pd    <= 1'b0;
    end else begin
      if (idle_ok) begin
        cmd_pll  <= 1'b0;
        cmd_chan <= 1'b0;
        cmd_pd   <= 1'b0;
      end
      if (wr_pend) begin
        unique case (wr_addr)
          `REG_CFG: begin
            sim_fast <= hwdata[`CFG_SIM_FAST];
            kind     <= hwdata[`CFG_KIND_MSB:`CFG_KIND_LSB];
          end
          `REG_CMD: begin
            cmd_pll  <= hwdata[`CMD_PLL];
            cmd_chan <= hwdata[`CMD_CHAN];
            cmd_pd   <= hwdata[`CMD_PD];
          end
          `REG_SCAN: scan_word <= hwdata[SCAN_BITS-1:0];
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // Reset sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state                <= xcvr_seq_pkg::S_IDLE;
      cnt                  <= '0;
      shreg                <= '0;
      lost_cnt             <= 8'h00;
      link.tx_coding_reset <= 1'b1;
      link.rx_analog_reset <= 1'b1;
      link.rx_coding_reset <= 1'b1;
      link.pll_reset       <= 1'b0;
      link.block_powerdown <= 1'b0;
      link.scan_valid      <= 1'b0;
      link.scan_data       <= 1'b0;
      link.scan_apply      <= 1'b0;
      link.commit_all      <= 1'b0;
      link.kind_sel        <= '0;
      link.elec_idle_force <= 1'b1;
    end else begin
      link.scan_apply <= 1'b0;
      link.commit_all <= 1'b0;
      cnt             <= cnt + 1'b1;
      link.elec_idle_force <= (state != xcvr_seq_pkg::S_READY); // R19
      unique case (state)
        xcvr_seq_pkg::S_IDLE, xcvr_seq_pkg::S_READY: begin
          if (cmd_pd && !link.busy) begin
            link.tx_coding_reset <= 1'b1; // R16
            link.rx_analog_reset <= 1'b1;
            link.rx_coding_reset <= 1'b1;
            link.block_powerdown <= 1'b1;
            cnt                  <= '0;
            state                <= xcvr_seq_pkg::S_PD;
          end else if (cmd_pll) begin
            link.tx_coding_reset <= 1'b1;
            link.rx_analog_reset <= 1'b1;
            link.rx_coding_reset <= 1'b1;
            shreg                <= scan_word;
            cnt                  <= '0;
            state                <= xcvr_seq_pkg::S_SHIFT;
          end else if (cmd_chan && !link.busy) begin
            link.kind_sel        <= kind; // R7
            link.commit_all      <= 1'b1;
            link.tx_coding_reset <= 1'b1;
            link.rx_analog_reset <= 1'b1;
            link.rx_coding_reset <= 1'b1;
            state                <= xcvr_seq_pkg::S_WAIT_UPD;
          end else if (state == xcvr_seq_pkg::S_IDLE && !link.busy) begin
            state <= xcvr_seq_pkg::S_WAIT_LOCK;
          end else if (state == xcvr_seq_pkg::S_READY && !link.pll_locked) begin
            link.tx_coding_reset <= 1'b1; // R20
            link.rx_analog_reset <= 1'b1;
            link.rx_coding_reset <= 1'b1;
            lost_cnt             <= lost_cnt + 1'b1;
            state                <= xcvr_seq_pkg::S_WAIT_LOCK;
          end
        end
        xcvr_seq_pkg::S_SHIFT: begin
          link.scan_valid <= 1'b1;
          link.scan_data  <= shreg[0];
          shreg           <= shreg >> 1;
          if (cnt == `CNT_W'(SCAN_BITS - 1))
            state <= xcvr_seq_pkg::S_APPLY;
        end
        xcvr_seq_pkg::S_APPLY: begin
          link.scan_valid <= 1'b0;
          link.scan_apply <= 1'b1; // R1
          state           <= xcvr_seq_pkg::S_WAIT_SCAN;
        end
        xcvr_seq_pkg::S_WAIT_SCAN: begin
          if (link.scan_done) begin
            link.pll_reset <= 1'b1; // R3
            cnt            <= '0;
            state          <= xcvr_seq_pkg::S_PLL_RST;
          end
        end
        xcvr_seq_pkg::S_PLL_RST: begin
          if (cnt == `CNT_W'(`PLLRST_CYCLES - 1)) begin
            link.pll_reset <= 1'b0;
            state          <= xcvr_seq_pkg::S_WAIT_LOCK;
          end
        end
        xcvr_seq_pkg::S_WAIT_UPD: begin
          if (link.update_done) begin
            link.tx_coding_reset <= 1'b0; // R10
            cnt                  <= '0;
            state                <= xcvr_seq_pkg::S_WAIT_ANALOG;
          end
        end
        xcvr_seq_pkg::S_WAIT_LOCK: begin
          if (link.pll_locked) begin
            link.tx_coding_reset <= 1'b0; // R4
            cnt                  <= '0;
            state                <= xcvr_seq_pkg::S_WAIT_ANALOG;
          end
        end
        xcvr_seq_pkg::S_WAIT_ANALOG: begin
          if (!link.pll_locked) begin
            link.tx_coding_reset <= 1'b1; // R20
            lost_cnt             <= lost_cnt + 1'b1;
            state                <= xcvr_seq_pkg::S_WAIT_LOCK;
          end else if (cnt == `CNT_W'(`ANALOG_WAIT_CYCLES - 1)) begin
            link.rx_analog_reset <= 1'b0; // R5 R11
            state                <= xcvr_seq_pkg::S_WAIT_DLOCK;
          end
        end
        xcvr_seq_pkg::S_WAIT_DLOCK, xcvr_seq_pkg::S_SETTLE: begin
          if (!link.pll_locked) begin
            link.tx_coding_reset <= 1'b1; // R20
            link.rx_analog_reset <= 1'b1;
            lost_cnt             <= lost_cnt + 1'b1;
            state                <= xcvr_seq_pkg::S_WAIT_LOCK;
          end else if (!link.data_lock) begin
            cnt   <= '0;
            state <= xcvr_seq_pkg::S_WAIT_DLOCK;
          end else if (sim_fast) begin
            link.rx_coding_reset <= 1'b0; // R18
            state                <= xcvr_seq_pkg::S_READY;
          end else if (state == xcvr_seq_pkg::S_WAIT_DLOCK) begin
            cnt   <= '0;
            state <= xcvr_seq_pkg::S_SETTLE;
          end else if (cnt == `CNT_W'(SETTLE_CYCLES - 1)) begin
            link.rx_coding_reset <= 1'b0; // R6 R12
            state                <= xcvr_seq_pkg::S_READY;
          end
        end
        xcvr_seq_pkg::S_PD: begin
          if (cnt == `CNT_W'(PD_CYCLES - 1)) begin
            link.block_powerdown <= 1'b0; // R13
            state                <= xcvr_seq_pkg::S_WAIT_LOCK;
          end
        end
        default: state <= xcvr_seq_pkg::S_IDLE;
      endcase
    end
  end
endmodule // xcvr_user_end
`default_nettype wire

// file: bench/xcvr_link_sva.sv
// Checker for the link between user reset logic and the transceiver.
// Assumes one clock for both ends; instantiated beside the link.
`timescale 1ns/1ps
`default_nettype none
module xcvr_link_sva #(
  parameter int PD_CYCLES = 100
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tx_coding_reset,
  input wire logic rx_analog_reset,
  input wire logic rx_coding_reset,
  input wire logic pll_reset,
  input wire logic block_powerdown,
  input wire logic scan_valid,
  input wire logic scan_apply,
  input wire logic commit_all,
  input wire logic pll_locked,
  input wire logic data_lock,
  input wire logic busy,
  input wire logic scan_done,
  input wire logic update_done
);
  // ==========================================================
  // Powerdown pulse length
  logic [15:0] pd_cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) pd_cnt <= 16'h0;
    else if (block_powerdown) pd_cnt <= pd_cnt + 16'h1;
    else pd_cnt <= 16'h0;
  end
  // ==========================================================
  // Properties
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_apply_after_scan: assert property (
    scan_apply |-> $past(scan_valid) && !scan_valid) else $error("apply not after last bit");
  a_scan_done_due: assert property (
    scan_apply |-> ##[8:10] scan_done) else $error("scan done missing");
  a_pll_rst_follows: assert property (
    scan_done |-> ##[1:2] pll_reset) else $error("no pll reset after scan done");
  a_pll_rst_width: assert property (
    $rose(pll_reset) |-> pll_reset [*4] ##1 !pll_reset) else $error("pll reset width");
  a_resets_in_pll_rst: assert property (
    pll_reset |-> tx_coding_reset && rx_analog_reset && rx_coding_reset)
    else $error("reset released during pll reset");
  a_tx_after_lock: assert property (
    $fell(tx_coding_reset) |-> pll_locked) else $error("tx released without lock");
  a_analog_five: assert property (
    $fell(rx_analog_reset) |-> $past(pll_locked, 5)) else $error("rx analog released early");
  a_tx_before_analog: assert property (
    $fell(rx_analog_reset) |-> !tx_coding_reset) else $error("tx still in reset");
  a_analog_after_done: assert property (
    update_done |-> rx_analog_reset [*5]) else $error("rx analog released too soon");
  a_coding_last: assert property (
    $fell(rx_coding_reset) |-> data_lock && !rx_analog_reset && !tx_coding_reset)
    else $error("rx coding released early");
  a_commit_resets: assert property (
    commit_all |-> ##[0:1] (tx_coding_reset && rx_analog_reset && rx_coding_reset))
    else $error("resets not asserted at commit");
  a_busy_at_commit: assert property (
    commit_all && !busy |=> busy) else $error("busy not raised at commit");
  a_done_at_fall: assert property (
    update_done |-> !busy && $past(busy)) else $error("update done not at busy fall");
  a_busy_cause: assert property (
    $rose(busy) |-> $past(commit_all) || $past(block_powerdown) || $past(block_powerdown, 2))
    else $error("busy raised without cause");
  a_busy_length: assert property (
    $rose(busy) |-> busy [*8] ##[11:13] !busy) else $error("busy length wrong");
  a_pd_width: assert property (
    $fell(block_powerdown) |-> pd_cnt >= PD_CYCLES) else $error("powerdown too short");
  a_pd_not_busy: assert property (
    $rose(block_powerdown) |-> !$past(busy)) else $error("powerdown during busy");
endmodule // xcvr_link_sva
`default_nettype wire

// file: bench/tb_transceiver_reconfig_reset_sequencer.sv
// Bench for the reset sequencer: both ends joined by the link.
// Assumes design files, package and header are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "xcvr_seq_defines.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %0t got=%h exp=%h", $time, g, e); end end
module tb_transceiver_reconfig_reset_sequencer;
  localparam logic [31:0] CFG = {24'h0, `REG_CFG};
  localparam logic [31:0] CMD = {24'h0, `REG_CMD};
  localparam logic [31:0] ST  = {24'h0, `REG_STATUS};
  localparam logic [31:0] SCN = {24'h0, `REG_SCAN};
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, link_up, chk_ph, prb;
  logic [31:0] haddr, hwdata, hrdata, rd, word, got_w, exp_w, rate_cfg;
  logic [1:0]  htrans, prb_sel;
  logic [2:0]  hsize;
  xcvr_seq_pkg::reconf_kind_t chan_kind;
  logic [31:0] exp_q[$];
  logic [31:0] ra[4] = '{32'h0, 32'h4, 32'hc, 32'h10};
  int          error_cnt, n_tests;
  xcvr_link_if xcvr_link_if_i ();
  xcvr_user_end #(.SETTLE_CYCLES(10), .PD_CYCLES(100)) xcvr_user_end_i (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .link(xcvr_link_if_i));
  xcvr_device_end xcvr_device_end_i (.hclk(hclk), .hresetn(hresetn), .link(xcvr_link_if_i),
    .link_up(link_up), .rate_cfg(rate_cfg), .chan_kind(chan_kind));
  xcvr_link_sva #(.PD_CYCLES(100)) xcvr_link_sva_i (.hclk(hclk), .hresetn(hresetn),
    .tx_coding_reset(xcvr_link_if_i.tx_coding_reset),
    .rx_analog_reset(xcvr_link_if_i.rx_analog_reset),
    .rx_coding_reset(xcvr_link_if_i.rx_coding_reset), .pll_reset(xcvr_link_if_i.pll_reset),
    .block_powerdown(xcvr_link_if_i.block_powerdown), .scan_valid(xcvr_link_if_i.scan_valid),
    .scan_apply(xcvr_link_if_i.scan_apply), .commit_all(xcvr_link_if_i.commit_all),
    .pll_locked(xcvr_link_if_i.pll_locked), .data_lock(xcvr_link_if_i.data_lock),
    .busy(xcvr_link_if_i.busy), .scan_done(xcvr_link_if_i.scan_done),
    .update_done(xcvr_link_if_i.update_done));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // ==========================================================
  // Result monitor
  always @(posedge hclk) begin
    if ((chk_ph && hreadyout === 1'b1) || prb) begin
      exp_w = exp_q.pop_front();
      got_w = !prb ? hrdata : prb_sel == 2'd0 ? rate_cfg :
              prb_sel == 2'd1 ? {29'h0, chan_kind} : {31'h0, link_up};
      `CHK(got_w, exp_w)
      if (chk_ph) `CHK(hresp, 1'b0)
    end
  end
  // ==========================================================
  // Bus and probe tasks
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                      input logic ck, input logic [31:0] e);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    if (ck) exp_q.push_back(e);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    chk_ph <= ck;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk_ph <= 1'b0;
  endtask
  task automatic wait_ready();
    repeat (3) @(posedge hclk);
    rd = 32'h0;
    while (rd[4] !== 1'b1) xfer(ST, 1'b0, 32'h0, 1'b0, 32'h0);
  endtask
  task automatic probe(input logic [1:0] s, input logic [31:0] e);
    exp_q.push_back(e);
    prb_sel <= s;
    prb <= 1'b1;
    @(posedge hclk);
    prb <= 1'b0;
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #500000;
    error_cnt++;
    complete_run();
  end
  // ==========================================================
  // Tests
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'b010; hwdata = 32'h0; chk_ph = 1'b0; prb = 1'b0; prb_sel = 2'd0;
    error_cnt = 0; n_tests = 0;
    void'($urandom(54));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(ST, 1'b0, 32'h0, 1'b1, 32'h20);
    foreach (ra[i]) xfer(ra[i], 1'b0, 32'h0, 1'b1, 32'h0);
    xfer(32'h10, 1'b1, $urandom, 1'b0, 32'h0);
    xfer(CFG, 1'b1, 32'he, 1'b0, 32'h0);
    xfer(CFG, 1'b0, 32'h0, 1'b1, 32'he);
    $display("test registers done");
    wait_ready();
    probe(2'd2, 32'h1);
    $display("test bring-up done");
    for (int p = 0; p < 2; p++) begin
      word = $urandom;
      xfer(CFG, 1'b1, p, 1'b0, 32'h0);
      xfer(SCN, 1'b1, word, 1'b0, 32'h0);
      xfer(SCN, 1'b0, 32'h0, 1'b1, word);
      xfer(CMD, 1'b1, 32'h1 << `CMD_PLL, 1'b0, 32'h0);
      wait_ready();
      probe(2'd0, word);
      xfer(ST, 1'b0, 32'h0, 1'b1, 32'hd9);
    end
    $display("test pll reconfiguration done");
    for (int k = 0; k < 8; k++) begin
      xfer(CFG, 1'b1, {28'h0, k[2:0], 1'b0}, 1'b0, 32'h0);
      xfer(CMD, 1'b1, 32'h1 << `CMD_CHAN, 1'b0, 32'h0);
      wait_ready();
      probe(2'd1, {29'h0, k[2:0]});
    end
    $display("test channel reconfiguration done");
    xfer(CMD, 1'b1, 32'h1 << `CMD_PD, 1'b0, 32'h0);
    wait_ready();
    probe(2'd2, 32'h1);
    $display("test powerdown done");
    xfer(CMD, 1'b1, 32'h1 << `CMD_CHAN, 1'b0, 32'h0);
    repeat (8) @(posedge hclk);
    hresetn <= 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(ST, 1'b0, 32'h0, 1'b1, 32'h20);
    wait_ready();
    probe(2'd2, 32'h1);
    $display("test mid-run reset done");
    complete_run();
  end
endmodule // tb_transceiver_reconfig_reset_sequencer
`default_nettype wire
